// *** mmu_pkg.sv ***
package mmu_pkg;
  localparam int ADDRESS_SPACE_IDENTIFIER_W = 8;
  localparam int CCA_W = 3;
  localparam int PFN_W = 20;
  localparam int LO_W = 27;
  localparam logic [CCA_W-1:0] CCA_UNCACHED = 3'h2;
  localparam logic [31:0] KERNEL_UNMAPPED_CACHED_SEGMENT_BASE = 32'h8000_0000;
  localparam logic [31:0] KERNEL_UNMAPPED_UNCACHED_SEGMENT_BASE = 32'ha000_0000;
  localparam logic [31:0] DSEG_LO = 32'hff20_0000;
  localparam logic [31:0] DSEG_HI = 32'hff3f_ffff;
  localparam logic [2:0] SEG_K0 = 3'h4;
  localparam logic [2:0] SEG_K1 = 3'h5;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDRESS_SPACE_IDENTIFIER = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_INDEX = 8'h0c;
  localparam logic [7:0] REG_TAG = 8'h10;
  localparam logic [7:0] REG_LO0 = 8'h14;
  localparam logic [7:0] REG_LO1 = 8'h18;
  localparam logic [7:0] REG_TLBWR = 8'h1c;
  localparam logic [7:0] REG_FAULT = 8'h20;
  localparam logic [7:0] REG_BADVA = 8'h24;
  // Field positions
  localparam int CTRL_UM = 0;
  localparam int CTRL_EXL = 1;
  localparam int CTRL_ERL = 2;
  localparam int CTRL_DM = 3;
  localparam int CTRL_DSEG = 4;
  localparam int CFG_K0 = 0;
  localparam int CFG_K23 = 3;
  localparam int CFG_KU = 6;
  localparam int TAG_ADDRESS_SPACE_IDENTIFIER = 0;
  localparam int TAG_G = 8;
  localparam int TAG_VPN2 = 13;
  localparam int LO_CCA = 20;
  localparam int LO_V = 23;
  localparam int LO_D = 24;
  localparam int LO_RI = 25;
  localparam int LO_XI = 26;
  localparam int PAGE_LSB = 12;

  typedef enum logic [1:0] {ACC_FETCH, ACC_LOAD, ACC_STORE} access_t;
  typedef enum logic [1:0] {EXC_NONE, EXC_ADDR, EXC_REFILL, EXC_PROT} exc_t;
  typedef struct packed {logic [31:0] va; access_t kind;} xlate_req_t;
  typedef struct packed {
    logic [31:0] pa; logic [CCA_W-1:0] cca; logic dseg; exc_t exc; access_t kind; logic [31:0] badva;
  } xlate_rsp_t;
  typedef struct packed {
    logic v; logic [19:0] vpn; logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier; logic g;
    logic [PFN_W-1:0] pfn; logic [CCA_W-1:0] cca; logic ri; logic xi; logic wp;
  } utlb_entry_t;
  typedef struct packed {
    logic [18:0] vpn2; logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier; logic g; logic [LO_W-1:0] lo0; logic [LO_W-1:0] lo1;
  } joint_translation_buffer_entry_t;
endpackage : mmu_pkg

// *** virtual_address_segment_mmu.sv ***
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Behaviour
// (RULE1) Translate every address before cache or bus
// (RULE2) Joint buffer 16/32 pairs, two 4-entry micros
// (RULE3) Micro buffer first, joint next, miss faults
// (RULE4) Fetch: joint after micro miss, refill micro
// (RULE5) Data: micro and joint together, refill micro
// (RULE6) Read, execute and write inhibits block access
// (RULE7) Fixed mapping keeps unmapped kernel translation
// (RULE8) Kernel mode on reset and on exception
// (RULE9) User mode: user bit, no levels, no debug
// (RULE10) Kernel mode: no debug, not user condition
// (RULE11) User access with bit 31 set faults
// (RULE12) Exception sets levels; return clears them
// (RULE13) Kernel segments decoded from bits 31:29
// (RULE14) Debug mode overlays switchable debug segment
// (RULE15) Unmapped uncached except cached low kernel segment
// (RULE16) Fixed mapping: two cacheability fields, no protect
// (RULE17) User space address carries space identifier
// (RULE18) User cacheability from matching page entry
// (RULE19) Error level: user space unmapped, uncached
// (RULE20) Unmapped kernel segments subtract their base
// (RULE21) Debug segment spans ff20_0000 to ff3f_ffff
// (RULE22) Faults reported with address and access kind
// (RULE23) Mode and segment decoded same cycle
module virtual_address_segment_mmu
  import mmu_pkg::*;
#(
  parameter int JOINT_TRANSLATION_BUFFER_ENTRIES = 16,
  parameter int MICRO_ENTRIES = 4,
  parameter bit USE_TLB = 1'b1
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  input wire logic req_valid_in,
  input wire xlate_req_t req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output xlate_rsp_t rsp_out,
  input wire logic exception_in,
  input wire logic error_exception_in,
  input wire logic exception_return_instr_in,
  input wire logic debug_exception_in,
  input wire logic debug_return_in,
  output logic user_mode_out,
  output logic kernel_mode_out,
  output logic debug_mode_out
);
  localparam int JIW = $clog2(JOINT_TRANSLATION_BUFFER_ENTRIES);
  localparam int MIW = $clog2(MICRO_ENTRIES);
  generate
    if (!(JOINT_TRANSLATION_BUFFER_ENTRIES == 16 || JOINT_TRANSLATION_BUFFER_ENTRIES == 32) || MICRO_ENTRIES != 4) begin : g_bad_cfg
      $error("Unsupported buffer sizes");
    end
  endgenerate
  typedef enum logic {ST_IDLE, ST_FETCH_JOINT_TRANSLATION_BUFFER} state_t;
  function automatic logic micro_match(utlb_entry_t e, logic [31:0] va, logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier);
    return e.v && e.vpn == va[31:PAGE_LSB] && (e.g || e.address_space_identifier == address_space_identifier);
  endfunction : micro_match
  function automatic utlb_entry_t to_micro(joint_translation_buffer_entry_t j, logic [31:0] va);
    logic [LO_W-1:0] lo;
    utlb_entry_t e;
    lo = va[PAGE_LSB] ? j.lo1 : j.lo0;
    e.v = 1'b1;
    e.vpn = va[31:PAGE_LSB];
    e.address_space_identifier = j.address_space_identifier;
    e.g = j.g;
    e.pfn = lo[PFN_W-1:0];
    e.cca = lo[LO_CCA +: CCA_W];
    e.ri = lo[LO_RI];
    e.xi = lo[LO_XI];
    e.wp = !lo[LO_D];
    return e;
  endfunction : to_micro
  state_t state_q;
  xlate_req_t held_q;
  logic um_q, exl_q, erl_q, dm_q, dseg_en_q;
  logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier_q;
  logic [8:0] config_q;
  logic [JIW-1:0] index_q;
  logic [31:0] tag_q;
  logic [LO_W-1:0] lo0_q, lo1_q;
  logic [31:0] badva_q;
  exc_t fault_q;
  joint_translation_buffer_entry_t joint_translation_buffer_q [JOINT_TRANSLATION_BUFFER_ENTRIES];
  utlb_entry_t instruction_micro_buffer_q [MICRO_ENTRIES];
  utlb_entry_t data_micro_buffer_q [MICRO_ENTRIES];
  logic [MIW-1:0] ifill_q, dfill_q;
  logic [JOINT_TRANSLATION_BUFFER_ENTRIES-1:0] jmatch;
  xlate_req_t cur;
  xlate_rsp_t rsp_d;
  logic user_c, take, need_joint_translation_buffer, fire, fault_c, fill_i, fill_d, flush;
  logic ihit, dhit, jhit;
  utlb_entry_t ient, dent, jent, use_ent;
  logic wr_tlb;
  assign take = req_valid_in && req_ready_out;
  assign wr_tlb = reg_write_in && reg_addr_in == REG_TLBWR;
  assign flush = wr_tlb || (reg_write_in && reg_addr_in == REG_ADDRESS_SPACE_IDENTIFIER);
  assign cur = (state_q == ST_FETCH_JOINT_TRANSLATION_BUFFER) ? held_q : req_in;
  assign user_c = um_q && !exl_q && !erl_q && !dm_q; // RULE9 RULE23
  // Joint buffer compare, one comparator per pair
  generate
    for (genvar gi = 0; gi < JOINT_TRANSLATION_BUFFER_ENTRIES; gi++) begin : g_jcmp
      assign jmatch[gi] = joint_translation_buffer_q[gi].vpn2 == cur.va[31:13] &&
        (joint_translation_buffer_q[gi].g || joint_translation_buffer_q[gi].address_space_identifier == address_space_identifier_q) && // RULE17
        (cur.va[PAGE_LSB] ? joint_translation_buffer_q[gi].lo1[LO_V] : joint_translation_buffer_q[gi].lo0[LO_V]);
    end
  endgenerate

  always_comb begin
    ihit = 1'b0;
    dhit = 1'b0;
    jhit = 1'b0;
    ient = '0;
    dent = '0;
    jent = '0;
    for (int i = 0; i < MICRO_ENTRIES; i++) begin
      if (!ihit && micro_match(instruction_micro_buffer_q[i], cur.va, address_space_identifier_q)) begin
        ihit = 1'b1;
        ient = instruction_micro_buffer_q[i];
      end
      if (!dhit && micro_match(data_micro_buffer_q[i], cur.va, address_space_identifier_q)) begin
        dhit = 1'b1;
        dent = data_micro_buffer_q[i];
      end
    end
    for (int i = 0; i < JOINT_TRANSLATION_BUFFER_ENTRIES; i++) begin
      if (!jhit && jmatch[i]) begin
        jhit = 1'b1;
        jent = to_micro(joint_translation_buffer_q[i], cur.va);
      end
    end
  end
  // Segment decode and translation of the presented address
  always_comb begin
    rsp_d.pa = cur.va;
    rsp_d.cca = CCA_UNCACHED;
    rsp_d.dseg = 1'b0;
    rsp_d.exc = EXC_NONE;
    rsp_d.kind = cur.kind;
    rsp_d.badva = cur.va;
    need_joint_translation_buffer = 1'b0;
    fill_i = 1'b0;
    fill_d = 1'b0;
    use_ent = '0;
    if (user_c && cur.va[31]) begin
      rsp_d.exc = EXC_ADDR; // RULE11
    end else if (dm_q && dseg_en_q && cur.va >= DSEG_LO && cur.va <= DSEG_HI) begin
      rsp_d.dseg = 1'b1; // RULE14 RULE21
    end else if (!cur.va[31] && erl_q) begin
      rsp_d.pa = cur.va; // RULE19
    end else if (cur.va[31:29] == SEG_K0) begin
      rsp_d.pa = cur.va - KERNEL_UNMAPPED_CACHED_SEGMENT_BASE; // RULE13 RULE20 RULE7
      rsp_d.cca = config_q[CFG_K0 +: CCA_W]; // RULE15
    end else if (cur.va[31:29] == SEG_K1) begin
      rsp_d.pa = cur.va - KERNEL_UNMAPPED_UNCACHED_SEGMENT_BASE; // RULE20 RULE7 RULE15
    end else if (!USE_TLB) begin
      rsp_d.pa = cur.va; // RULE16
      rsp_d.cca = cur.va[31] ? config_q[CFG_K23 +: CCA_W] : config_q[CFG_KU +: CCA_W];
    end else begin
      if (cur.kind == ACC_FETCH) begin
        if (state_q == ST_IDLE) begin
          if (ihit) begin
            use_ent = ient; // RULE3
          end else begin
            need_joint_translation_buffer = 1'b1; // RULE4
          end
        end else if (jhit) begin
          use_ent = jent;
          fill_i = 1'b1; // RULE4
        end else begin
          rsp_d.exc = EXC_REFILL; // RULE4
        end
      end else if (dhit) begin
        use_ent = dent; // RULE5
      end else if (jhit) begin
        use_ent = jent;
        fill_d = 1'b1; // RULE5
      end else begin
        rsp_d.exc = EXC_REFILL; // RULE3 RULE5
      end
      if (!need_joint_translation_buffer && rsp_d.exc == EXC_NONE) begin
        rsp_d.pa = {use_ent.pfn, cur.va[PAGE_LSB-1:0]}; // RULE1
        rsp_d.cca = use_ent.cca; // RULE18
        if ((cur.kind == ACC_FETCH && use_ent.xi) || (cur.kind == ACC_LOAD && use_ent.ri) ||
            (cur.kind == ACC_STORE && use_ent.wp)) begin
          rsp_d.exc = EXC_PROT; // RULE6
        end
      end
    end
  end
  assign fire = (take && !need_joint_translation_buffer) || state_q == ST_FETCH_JOINT_TRANSLATION_BUFFER;
  assign fault_c = fire && rsp_d.exc != EXC_NONE;
  // Request sequencing; a fetch that misses the micro buffer takes a second cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      held_q <= '0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      rsp_valid_out <= fire;
      if (fire) begin
        rsp_out <= rsp_d; // RULE22
      end
      if (state_q == ST_IDLE && take && need_joint_translation_buffer) begin
        state_q <= ST_FETCH_JOINT_TRANSLATION_BUFFER;
        held_q <= req_in;
        req_ready_out <= 1'b0;
      end else begin
        state_q <= ST_IDLE;
        req_ready_out <= 1'b1;
      end
    end
  end
  // Status bits; hardware events win over a software write in the same cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      um_q <= 1'b0;
      exl_q <= 1'b0;
      erl_q <= 1'b1; // RULE8
      dm_q <= 1'b0;
      dseg_en_q <= 1'b1;
    end else begin
      if (reg_write_in && reg_addr_in == REG_CTRL) begin
        um_q <= reg_wdata_in[CTRL_UM];
        exl_q <= reg_wdata_in[CTRL_EXL];
        erl_q <= reg_wdata_in[CTRL_ERL];
        dm_q <= reg_wdata_in[CTRL_DM];
        dseg_en_q <= reg_wdata_in[CTRL_DSEG];
      end
      if (exception_return_instr_in) begin
        if (erl_q) begin
          erl_q <= 1'b0; // RULE12
        end else begin
          exl_q <= 1'b0; // RULE12
        end
      end
      if (exception_in || (fault_c && !dm_q)) begin
        if (error_exception_in) begin
          erl_q <= 1'b1; // RULE8 RULE12
        end else begin
          exl_q <= 1'b1; // RULE8 RULE12
        end
      end
      if (debug_return_in) begin
        dm_q <= 1'b0;
      end
      if (debug_exception_in) begin
        dm_q <= 1'b1; // RULE14
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_mode_out <= 1'b0;
      kernel_mode_out <= 1'b1;
      debug_mode_out <= 1'b0;
    end else begin
      user_mode_out <= user_c; // RULE9
      kernel_mode_out <= !dm_q && (!um_q || erl_q || exl_q); // RULE10
      debug_mode_out <= dm_q;
    end
  end
  // Software staging registers and fault capture
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      address_space_identifier_q <= '0;
      config_q <= {CCA_UNCACHED, CCA_UNCACHED, CCA_UNCACHED};
      index_q <= '0;
      tag_q <= '0;
      lo0_q <= '0;
      lo1_q <= '0;
      badva_q <= '0;
      fault_q <= EXC_NONE;
    end else begin
      if (reg_write_in) begin
        case (reg_addr_in)
          REG_ADDRESS_SPACE_IDENTIFIER: address_space_identifier_q <= reg_wdata_in[ADDRESS_SPACE_IDENTIFIER_W-1:0];
          REG_CONFIG: config_q <= reg_wdata_in[8:0];
          REG_INDEX: index_q <= reg_wdata_in[JIW-1:0];
          REG_TAG: tag_q <= reg_wdata_in;
          REG_LO0: lo0_q <= reg_wdata_in[LO_W-1:0];
          REG_LO1: lo1_q <= reg_wdata_in[LO_W-1:0];
          default: ;
        endcase
      end
      if (fault_c) begin
        badva_q <= rsp_d.badva; // RULE22
        fault_q <= rsp_d.exc;
      end
    end
  end
  // Buffer contents; micro buffers flushed on any joint write or identifier change
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < JOINT_TRANSLATION_BUFFER_ENTRIES; i++) joint_translation_buffer_q[i] <= '0;
      for (int i = 0; i < MICRO_ENTRIES; i++) begin
        instruction_micro_buffer_q[i] <= '0;
        data_micro_buffer_q[i] <= '0;
      end
      ifill_q <= '0;
      dfill_q <= '0;
    end else begin
      if (wr_tlb) begin
        joint_translation_buffer_q[index_q] <= {tag_q[31:TAG_VPN2], tag_q[TAG_ADDRESS_SPACE_IDENTIFIER +: ADDRESS_SPACE_IDENTIFIER_W], tag_q[TAG_G], lo0_q, lo1_q}; // RULE2
      end
      if (flush) begin
        for (int i = 0; i < MICRO_ENTRIES; i++) begin
          instruction_micro_buffer_q[i].v <= 1'b0;
          data_micro_buffer_q[i].v <= 1'b0;
        end
      end else begin
        if (fill_i && fire) begin
          instruction_micro_buffer_q[ifill_q] <= jent; // RULE4
          ifill_q <= ifill_q + 1'b1;
        end
        if (fill_d && fire) begin
          data_micro_buffer_q[dfill_q] <= jent; // RULE5
          dfill_q <= dfill_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        REG_CTRL: reg_rdata_out <= {27'h0, dseg_en_q, dm_q, erl_q, exl_q, um_q};
        REG_ADDRESS_SPACE_IDENTIFIER: reg_rdata_out <= {24'h0, address_space_identifier_q};
        REG_CONFIG: reg_rdata_out <= {23'h0, config_q};
        REG_INDEX: reg_rdata_out <= 32'(index_q);
        REG_TAG: reg_rdata_out <= tag_q;
        REG_LO0: reg_rdata_out <= 32'(lo0_q);
        REG_LO1: reg_rdata_out <= 32'(lo1_q);
        REG_FAULT: reg_rdata_out <= 32'(fault_q);
        REG_BADVA: reg_rdata_out <= badva_q;
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  property p_user_mode;
    @(posedge clock_in) disable iff (!reset_n_in)
      user_mode_out |-> $past(um_q && !exl_q && !erl_q && !dm_q) && !kernel_mode_out;
  endproperty
  a_user_mode: assert property (p_user_mode) else $error("User mode wrongly reported"); // RULE9
  property p_kernel_mode;
    @(posedge clock_in) disable iff (!reset_n_in)
      ($past(!dm_q && erl_q)) |-> kernel_mode_out && !user_mode_out;
  endproperty
  a_kernel_mode: assert property (p_kernel_mode) else $error("Kernel mode not reported"); // RULE10
  property p_addr_err;
    @(posedge clock_in) disable iff (!reset_n_in)
      take && user_c && req_in.va[31] |=> rsp_valid_out && rsp_out.exc == EXC_ADDR ##1 exl_q;
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("User high address not faulted"); // RULE11
  property p_kernel_unmapped_uncached_segment;
    @(posedge clock_in) disable iff (!reset_n_in)
      take && !user_c && !erl_q && req_in.va[31:29] == SEG_K1 |=>
        rsp_valid_out && rsp_out.pa == $past(req_in.va) - KERNEL_UNMAPPED_UNCACHED_SEGMENT_BASE && rsp_out.cca == CCA_UNCACHED;
  endproperty
  a_kernel_unmapped_uncached_segment: assert property (p_kernel_unmapped_uncached_segment) else $error("Uncached kernel segment wrong"); // RULE20
  property p_exc_level;
    @(posedge clock_in) disable iff (!reset_n_in)
      exception_in && !error_exception_in |=> exl_q ##1 !user_mode_out;
  endproperty
  a_exc_level: assert property (p_exc_level) else $error("Exception did not enter kernel"); // RULE8
  property p_exception_return_instr;
    @(posedge clock_in) disable iff (!reset_n_in)
      exception_return_instr_in && !exception_in && !fault_c && erl_q && !reg_write_in |=>
        !erl_q && exl_q == $past(exl_q);
  endproperty
  a_exception_return_instr: assert property (p_exception_return_instr) else $error("Return cleared wrong level"); // RULE12
  property p_fetch_joint_translation_buffer;
    @(posedge clock_in) disable iff (!reset_n_in)
      take && need_joint_translation_buffer |=> !rsp_valid_out && !req_ready_out ##1 rsp_valid_out && req_ready_out;
  endproperty
  a_fetch_joint_translation_buffer: assert property (p_fetch_joint_translation_buffer) else $error("Fetch miss timing wrong"); // RULE4
  property p_erl_useg;
    @(posedge clock_in) disable iff (!reset_n_in)
      take && erl_q && !dm_q && !req_in.va[31] |=>
        rsp_out.pa == $past(req_in.va) && rsp_out.cca == CCA_UNCACHED && rsp_out.exc == EXC_NONE;
  endproperty
  a_erl_useg: assert property (p_erl_useg) else $error("Error level user space mapped"); // RULE19
endmodule : virtual_address_segment_mmu

// *** xlate_requester.sv ***
`timescale 1ns/1ps
// Pipeline side of the translation port: holds each request until taken
module xlate_requester
  import mmu_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire xlate_req_t start_req_in,
  input wire logic req_ready_in,
  input wire logic rsp_valid_in,
  input wire xlate_rsp_t rsp_in,
  output logic req_valid_out,
  output xlate_req_t req_out,
  output logic done_out,
  output xlate_rsp_t rsp_out
);
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_valid_out <= 1'b0;
      req_out <= '0;
    end else if (start_in) begin
      req_valid_out <= 1'b1;
      req_out <= start_req_in;
    end else if (req_valid_out && req_ready_in) begin
      req_valid_out <= 1'b0;
      // Released lines flip so a stale address is never mistaken for a request
      req_out <= ~req_out;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      done_out <= rsp_valid_in;
      if (rsp_valid_in) begin
        rsp_out <= rsp_in;
      end
    end
  end
endmodule : xlate_requester

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench import mmu_pkg::*;;
  logic clock_in;
  logic reset_n_in;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic req_valid;
  xlate_req_t req;
  logic req_ready;
  logic rsp_valid;
  xlate_rsp_t rsp;
  // Bits: exception, error qualifier, return, debug entry, debug exit
  logic [4:0] events;
  logic user_mode;
  logic kernel_mode;
  logic debug_mode;
  logic start;
  xlate_req_t start_req;
  logic done;
  xlate_rsp_t seen;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  virtual_address_segment_mmu i_virtual_address_segment_mmu (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_write_in(reg_write), .reg_read_in(reg_read), .reg_rdata_out(reg_rdata),
    .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
    .rsp_out(rsp), .exception_in(events[0]), .error_exception_in(events[1]),
    .exception_return_instr_in(events[2]), .debug_exception_in(events[3]), .debug_return_in(events[4]),
    .user_mode_out(user_mode), .kernel_mode_out(kernel_mode), .debug_mode_out(debug_mode)
  );

  xlate_requester i_xlate_requester (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .start_in(start), .start_req_in(start_req),
    .req_ready_in(req_ready), .rsp_valid_in(rsp_valid), .rsp_in(rsp), .req_valid_out(req_valid),
    .req_out(req), .done_out(done), .rsp_out(seen)
  );

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, mismatches);
  endtask : end_test

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock_in);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock_in);
    reg_read <= 1'b0;
    @(negedge clock_in);
    `CHECK("register data", e, reg_rdata)
  endtask : check_reg

  task automatic pulse(input logic [4:0] bits);
    @(posedge clock_in);
    events <= bits;
    @(posedge clock_in);
    events <= 5'h00;
  endtask : pulse

  // Mode outputs trail status events by two edges
  task automatic check_mode(input logic u, input logic k, input logic d);
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    `CHECK("user mode", u, user_mode)
    `CHECK("kernel mode", k, kernel_mode)
    `CHECK("debug mode", d, debug_mode)
  endtask : check_mode

  task automatic check_xlate(input logic [31:0] va, input access_t kind, input logic [31:0] pa,
                             input logic [2:0] cca, input exc_t exc);
    int n;
    n = 0;
    @(posedge clock_in);
    start <= 1'b1;
    start_req <= '{va: va, kind: kind};
    @(posedge clock_in);
    start <= 1'b0;
    do begin
      @(negedge clock_in);
      n++;
    end while (done !== 1'b1 && n < 20);
    `CHECK("response", 1'b1, done)
    `CHECK("fault code", exc, seen.exc)
    if (exc == EXC_NONE) begin
      `CHECK("physical address", pa, seen.pa)
      `CHECK("cacheability", cca, seen.cca)
    end else begin
      `CHECK("fault address", va, seen.badva)
      `CHECK("fault kind", kind, seen.kind)
    end
  endtask : check_xlate

  initial begin
    reset_n_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    events = 5'h00;
    start = 1'b0;
    start_req = '0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check_mode(1'b0, 1'b1, 1'b0);
    check_reg(REG_CTRL, 32'h0000_0014);
    check_reg(REG_CONFIG, 32'h0000_0092);
    check_reg(REG_ADDRESS_SPACE_IDENTIFIER, 32'h0000_0000);
    check_reg(8'h40, 32'h0000_0000);
    end_test("reset");
    check_xlate(32'h1234_5678, ACC_LOAD, 32'h1234_5678, CCA_UNCACHED, EXC_NONE);
    reg_wr(REG_CONFIG, 32'h0000_0093);
    check_xlate(32'h8123_4560, ACC_FETCH, 32'h0123_4560, 3'h3, EXC_NONE);
    check_xlate(32'hbfff_fffc, ACC_STORE, 32'h1fff_fffc, CCA_UNCACHED, EXC_NONE);
    end_test("unmapped");
    reg_wr(REG_CTRL, 32'h0000_0011);
    check_mode(1'b1, 1'b0, 1'b0);
    check_xlate(32'h8000_0000, ACC_LOAD, 32'h0, 3'h0, EXC_ADDR);
    check_mode(1'b0, 1'b1, 1'b0);
    check_reg(REG_BADVA, 32'h8000_0000);
    pulse(5'h04);
    check_mode(1'b1, 1'b0, 1'b0);
    reg_wr(REG_CTRL, 32'h0000_0017);
    pulse(5'h04);
    check_reg(REG_CTRL, 32'h0000_0013);
    check_mode(1'b0, 1'b1, 1'b0);
    pulse(5'h04);
    check_reg(REG_CTRL, 32'h0000_0011);
    pulse(5'h03);
    check_reg(REG_CTRL, 32'h0000_0015);
    check_mode(1'b0, 1'b1, 1'b0);
    pulse(5'h01);
    check_reg(REG_CTRL, 32'h0000_0017);
    end_test("modes");
    reg_wr(REG_CTRL, 32'h0000_0010);
    check_xlate(32'ha000_0010, ACC_LOAD, 32'h0000_0010, CCA_UNCACHED, EXC_NONE);
    reg_wr(REG_ADDRESS_SPACE_IDENTIFIER, 32'h0000_0005);
    reg_wr(REG_INDEX, 32'h0000_0000);
    reg_wr(REG_TAG, 32'h0000_4005);
    reg_wr(REG_LO0, 32'h01b1_2345);
    reg_wr(REG_LO1, 32'h02b0_0abc);
    reg_wr(REG_TLBWR, 32'h0000_0000);
    reg_wr(REG_INDEX, 32'h0000_0001);
    reg_wr(REG_TAG, 32'h0000_6005);
    reg_wr(REG_LO0, 32'h0580_0077);
    reg_wr(REG_TLBWR, 32'h0000_0000);
    check_xlate(32'h0000_4010, ACC_LOAD, 32'h1234_5010, 3'h3, EXC_NONE);
    check_xlate(32'h0000_4014, ACC_LOAD, 32'h1234_5014, 3'h3, EXC_NONE);
    check_xlate(32'h0000_4020, ACC_FETCH, 32'h1234_5020, 3'h3, EXC_NONE);
    check_xlate(32'h0000_5000, ACC_STORE, 32'h0, 3'h0, EXC_PROT);
    check_xlate(32'h0000_5004, ACC_LOAD, 32'h0, 3'h0, EXC_PROT);
    check_xlate(32'h0000_5008, ACC_FETCH, 32'h00ab_c008, 3'h3, EXC_NONE);
    check_xlate(32'h0000_6000, ACC_FETCH, 32'h0, 3'h0, EXC_PROT);
    check_xlate(32'h0000_6000, ACC_LOAD, 32'h0007_7000, 3'h0, EXC_NONE);
    reg_wr(REG_ADDRESS_SPACE_IDENTIFIER, 32'h0000_0006);
    check_xlate(32'h0000_4010, ACC_LOAD, 32'h0, 3'h0, EXC_REFILL);
    check_reg(REG_BADVA, 32'h0000_4010);
    check_reg(REG_FAULT, 32'h0000_0002);
    check_xlate(32'h0080_0000, ACC_FETCH, 32'h0, 3'h0, EXC_REFILL);
    end_test("mapped");
    pulse(5'h08);
    check_mode(1'b0, 1'b0, 1'b1);
    check_xlate(32'hff20_0000, ACC_LOAD, 32'hff20_0000, CCA_UNCACHED, EXC_NONE);
    `CHECK("debug segment", 1'b1, seen.dseg)
    check_xlate(32'hff3f_fffc, ACC_FETCH, 32'hff3f_fffc, CCA_UNCACHED, EXC_NONE);
    `CHECK("debug segment", 1'b1, seen.dseg)
    check_xlate(32'hff1f_fffc, ACC_LOAD, 32'h0, 3'h0, EXC_REFILL);
    `CHECK("debug segment", 1'b0, seen.dseg)
    reg_wr(REG_CTRL, 32'h0000_0008);
    check_xlate(32'hff20_0000, ACC_LOAD, 32'h0, 3'h0, EXC_REFILL);
    `CHECK("debug segment", 1'b0, seen.dseg)
    pulse(5'h10);
    check_mode(1'b0, 1'b1, 1'b0);
    end_test("debug");
    finish_test();
  end
endmodule : testbench
